//--- dv/hdp_bus_sva.sv
// assertions on the host bus between the processor end and the device end
`timescale 1ns/1ps
`default_nettype none
module hdp_bus_sva (
  // clock and reset
  input wire logic              clock,
  input wire logic              sys_rst,
  // host bus
  input wire logic              wr_stb,
  input wire logic              rd_stb,
  input wire hdp_pkg::dw_addr_t dw_addr,
  input wire logic              halfword_address_bit,
  input wire logic              rvalid
);
  import hdp_pkg::*;
  // ====
  // pairing tracker
  logic     pend_q;
  logic     bit_q;
  logic     wr_q;
  dw_addr_t addr_q;
  wire logic stb = wr_stb | rd_stb;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
    end else if (stb) begin
      pend_q <= !pend_q;
      bit_q  <= halfword_address_bit;
      wr_q   <= wr_stb;
      addr_q <= dw_addr;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ====
  // checks
  a_pair_addr: assert property (stb && pend_q |-> dw_addr == addr_q)
    else $error("address moved inside a pair");
  a_pair_half: assert property (stb && pend_q |-> halfword_address_bit != bit_q)
    else $error("second access hit the same half");
  a_pair_kind: assert property (stb && pend_q |-> wr_stb == wr_q)
    else $error("pair mixes read and write");
  a_stb_space: assert property (stb |=> !stb)
    else $error("strobes too close");
  a_pair_done: assert property (stb && !pend_q |-> ##[2:4] stb)
    else $error("second half late");
  a_read_first: assert property (rd_stb && !pend_q |-> ##2 rvalid)
    else $error("first read not answered");
  a_read_second: assert property (rd_stb && pend_q |-> ##1 rvalid)
    else $error("second read not answered");
  a_rvalid_cause: assert property (rvalid |-> $past(rd_stb) || $past(rd_stb, 2))
    else $error("answer without read");
endmodule : hdp_bus_sva
`default_nettype wire

//--- dv/host_halfword_dword_datapath_tb.sv
// end to end bench: processor end against device end, plus a rule breaking driver
`timescale 1ns/1ps
`default_nettype none
module host_halfword_dword_datapath_tb;
  import hdp_pkg::*;
  logic     clock = 0, sys_rst = 1, port_big = 0, direct_big = 0;
  logic     req_valid = 0, req_write = 0, req_high_first = 0, req_fifo_sel = 0;
  logic     req_ready, resp_valid, commit_valid, commit_valid2, dropped2, restart2;
  logic     fetch_req, dropped1, restart1;
  dw_addr_t req_addr = 5'h00;
  dword_t   req_wdata = 32'h0, swap_ctrl = 32'h0, fetch_data = 32'h5a69_7887;
  dword_t   resp_data, commit_data, commit_data2;
  target_e  commit_target, fetch_target;
  dw_addr_t commit_addr, fetch_addr;
  int       error_cnt = 0, checks = 0, cyc = 0, ndrop = 0, nrst = 0, ncom = 0;
  int       nfetch = 0, nbad = 0;
  hdp_if bus ();
  hdp_if bus2 ();
  hdp_host hdp_host_inst (.clock, .sys_rst, .bus(bus.host), .req_valid, .req_write,
    .req_high_first, .req_fifo_sel, .req_addr, .req_wdata, .req_ready, .resp_valid, .resp_data);
  hdp_device hdp_device_inst (.clock, .sys_rst, .bus(bus.device),
    .fifo_port_big_endian(port_big), .fifo_direct_big_endian(direct_big), .swap_ctrl,
    .commit_valid, .commit_data, .commit_target, .commit_addr, .write_dropped(dropped1),
    .fetch_req, .fetch_target, .fetch_addr, .fetch_data, .read_restart(restart1));
  // second device end faces a driver that breaks the pairing on purpose
  hdp_device hdp_device_inst2 (.clock, .sys_rst, .bus(bus2.device),
    .fifo_port_big_endian(port_big), .fifo_direct_big_endian(direct_big), .swap_ctrl,
    .commit_valid(commit_valid2), .commit_data(commit_data2), .commit_target(),
    .commit_addr(), .write_dropped(dropped2), .fetch_req(), .fetch_target(),
    .fetch_addr(), .fetch_data, .read_restart(restart2));
  hdp_bus_sva hdp_bus_sva_inst (.clock, .sys_rst, .wr_stb(bus.wr_stb), .rd_stb(bus.rd_stb),
    .dw_addr(bus.dw_addr), .halfword_address_bit(bus.halfword_address_bit),
    .rvalid(bus.rvalid));
  always #2.5 clock = ~clock;
  // ====
  // helpers
  function automatic dword_t rev(dword_t x);
    return {x[7:0], x[15:8], x[23:16], x[31:24]};
  endfunction : rev
  function automatic dword_t rot(dword_t x);
    return {x[15:0], x[31:16]};
  endfunction : rot
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  task automatic xfer(input logic w, hf, fs, input dw_addr_t a, input dword_t d);
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= w;
    req_high_first <= hf;
    req_fifo_sel <= fs;
    req_addr <= a;
    req_wdata <= d;
    @(negedge clock);
    while (req_ready !== 1'b1) @(negedge clock);
    @(posedge clock);
    req_valid <= 1'b0;
    repeat (30) begin
      @(negedge clock);
      if (w ? commit_valid : resp_valid) break;
    end
    chk("done", w ? commit_valid : resp_valid, 32'h1);
  endtask : xfer
  task automatic hw(input logic w, b, input half_t d);
    @(posedge clock);
    bus2.wr_stb <= w;
    bus2.rd_stb <= !w;
    bus2.halfword_address_bit <= b;
    bus2.wdata <= d;
    @(posedge clock);
    bus2.wr_stb <= 1'b0;
    bus2.rd_stb <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : hw
  // hang guard, also counts pulses of the second device end
  always @(negedge clock) begin
    cyc++;
    ndrop += dropped2;
    nrst += restart2;
    ncom += commit_valid2;
    nfetch += fetch_req;
    nbad += dropped1;
    nbad += restart1;
    if (cyc == 3000) begin
      error_cnt++;
      test_done();
    end
  end
  // ====
  // main sequence
  initial begin
    bus2.wr_stb = 0;
    bus2.rd_stb = 0;
    bus2.dw_addr = 5'h02;
    bus2.halfword_address_bit = 0;
    bus2.fifo_sel = 0;
    bus2.wdata = 16'h0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    // every endian and swap mix on port, direct and status paths, boundary addresses
    for (int i = 0; i < 24; i++) begin
      logic     big, fs;
      dw_addr_t a;
      dword_t   d, t;
      target_e  g;
      @(posedge clock);
      port_big <= i[0];
      direct_big <= i[1];
      swap_ctrl <= i[2] ? 32'hffff_ffff : 32'hffff_fffe;
      fs = (i / 8 == 1);
      a = (i / 8 == 0) ? 5'h0f : (fs ? 5'h03 : 5'h10);
      big = (i / 8 == 0) ? i[0] : (fs ? i[1] : 1'b0);
      d = 32'hc1d2_e3f4 ^ i;
      xfer(1'b1, i[1] ^ i[2], fs, a, d);
      t = i[2] ? rot(d) : d;
      chk("commit_data", commit_data, big ? rev(t) : t);
      g = fs ? TGT_DATA_DIRECT : (i / 8 == 0 ? TGT_DATA_PORT : TGT_STATUS_FIFO);
      chk("commit_target", commit_target, g);
      chk("commit_addr", commit_addr, a);
      xfer(1'b0, i[0] ^ i[2], fs, a, 32'h0);
      t = big ? rev(fetch_data) : fetch_data;
      chk("resp_data", resp_data, i[2] ? rot(t) : t);
      chk("fetch_target", fetch_target, g);
      chk("fetch_addr", fetch_addr, a);
    end
    @(posedge clock);
    port_big <= 1'b0;
    swap_ctrl <= 32'h0;
    hw(1'b1, 1'b0, 16'h3344);
    hw(1'b1, 1'b0, 16'h5566);
    chk("drop_count", ndrop, 32'h1);
    chk("commit_count", ncom, 32'h0);
    hw(1'b1, 1'b1, 16'h7788);
    hw(1'b1, 1'b0, 16'h99aa);
    chk("commit_count", ncom, 32'h1);
    chk("commit_data2", commit_data2, 32'h7788_99aa);
    hw(1'b0, 1'b1, 16'h0);
    hw(1'b0, 1'b1, 16'h0);
    chk("restart_count", nrst, 32'h1);
    hw(1'b0, 1'b0, 16'h0);
    chk("rdata2_pair", bus2.rdata, fetch_data[15:0]);
    hw(1'b0, 1'b1, 16'h0);
    chk("restart_count", nrst, 32'h1);
    chk("rdata2", bus2.rdata, fetch_data[31:16]);
    chk("fetch_count", nfetch, 32'h18);
    chk("main_bad", nbad, 32'h0);
    test_done();
  end
endmodule : host_halfword_dword_datapath_tb
`default_nettype wire

//--- logic/hdp_device.sv
// device end: halfword pairing, endian reordering and halfword swap
`timescale 1ns/1ps
`default_nettype none
`include "hdp_cfg.svh"
module hdp_device #(
  parameter int PORT_TOP_DW = 15
) (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            sys_rst,
  // host bus
  hdp_if.device                bus,
  // configuration
  input  wire logic            fifo_port_big_endian,
  input  wire logic            fifo_direct_big_endian,
  input  wire hdp_pkg::dword_t swap_ctrl,
  // internal write side
  output logic                 commit_valid,
  output hdp_pkg::dword_t      commit_data,
  output hdp_pkg::target_e     commit_target,
  output hdp_pkg::dw_addr_t    commit_addr,
  output logic                 write_dropped,
  // internal read side
  output logic                 fetch_req,
  output hdp_pkg::target_e     fetch_target,
  output hdp_pkg::dw_addr_t    fetch_addr,
  input  wire hdp_pkg::dword_t fetch_data,
  output logic                 read_restart
);
  import hdp_pkg::*;

  // =========================================================
  // decoding
  // upper addresses without fifo_sel reach the status fifo, which is endian neutral
  function automatic target_e decode(input dw_addr_t a, input logic sel);
    if (sel) begin
      decode = TGT_DATA_DIRECT;
    end else if (a <= dw_addr_t'(PORT_TOP_DW)) begin
      decode = TGT_DATA_PORT;
    end else begin
      decode = TGT_STATUS_FIFO;
    end
  endfunction : decode

  // R7 separate endian selects
  function automatic logic big_for(input target_e t, input logic pe, input logic de);
    unique case (t)
      // R8 port path select
      TGT_DATA_PORT:   big_for = pe;
      // R9 direct path select
      TGT_DATA_DIRECT: big_for = de;
      // R10 csr and status unaffected
      default:         big_for = 1'b0;
    endcase
  endfunction : big_for

  // R13 R14 reverse bytes for big endian
  function automatic dword_t endian(input dword_t d, input logic big);
    endian = big ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction : endian

  // R15 swap halves only on exact all ones
  // the swap exchanges the two halves and keeps byte order inside each
  function automatic dword_t hswap(input dword_t d, input logic sw);
    hswap = sw ? {d[15:0], d[31:16]} : d;
  endfunction : hswap

  // =========================================================
  // state
  typedef struct packed {
    // write pairing
    logic     have_w;
    logic     w_half;
    half_t    w_stage;
    // read pairing
    logic     have_r;
    logic     r_half;
    dword_t   r_stage;
    // commit outputs
    logic     cv;
    dword_t   cd;
    target_e  ct;
    dw_addr_t ca;
    logic     wd;
    // fetch outputs
    logic     fr;
    target_e  ft;
    dw_addr_t fa;
    logic     rr;
    // answer on the host bus
    half_t    rd;
    logic     rv;
    // fetch in flight
    logic     pend_rd;
    logic     pend_half;
    logic     pend_big;
  } state_s;

  state_s s_q, s_d;
  logic   swap_on;

  // R15 exact all ones compare
  // a value one bit short of all ones leaves the halves in place
  assign swap_on = (swap_ctrl == `HDP_SWAP_ALL_ONES);

  // =========================================================
  // next state
  // staging, drop and restart decided here; outputs follow one cycle later

  always_comb begin
    target_e t;
    logic    big;
    dword_t  raw;
    dword_t  inw;
    t   = decode(bus.dw_addr, bus.fifo_sel);
    big = big_for(t, fifo_port_big_endian, fifo_direct_big_endian);
    raw = '0;
    inw = '0;
    s_d = s_q;
    s_d.cv = 1'b0;
    s_d.wd = 1'b0;
    s_d.fr = 1'b0;
    s_d.rr = 1'b0;
    s_d.rv = 1'b0;
    s_d.pend_rd = 1'b0;
    if (bus.wr_stb) begin
      if (!s_q.have_w) begin
        // R16 stage first half
        // the first half waits here until its partner arrives
        s_d.have_w  = 1'b1;
        s_d.w_half  = bus.halfword_address_bit;
        s_d.w_stage = bus.wdata;
      end else if (s_q.w_half == bus.halfword_address_bit) begin
        // R4 same half twice drops
        // staging is emptied so the next write opens a fresh pair
        s_d.have_w = 1'b0;
        s_d.wd     = 1'b1;
      end else begin
        // R3 either order accepted
        raw = bus.halfword_address_bit ? {bus.wdata, s_q.w_stage}
                                       : {s_q.w_stage, bus.wdata};
        // R11 R12 swap then endian
        inw = endian(hswap(raw, swap_on), big);
        s_d.have_w = 1'b0;
        s_d.cv     = 1'b1;
        s_d.cd     = inw;
        s_d.ct     = t;
        // second write's address is used; the pair shares its upper bits
        s_d.ca     = bus.dw_addr;
      end
    end
    if (bus.rd_stb) begin
      // second half of a pair is served from the staged dword, no new fetch
      if (s_q.have_r && s_q.r_half != bus.halfword_address_bit) begin
        s_d.have_r = 1'b0;
        s_d.rv     = 1'b1;
        s_d.rd     = bus.halfword_address_bit ? s_q.r_stage[31:16] : s_q.r_stage[15:0];
      end else begin
        // R6 repeat restarts the pairing
        // restart is flagged only when a first half was already held
        s_d.rr        = s_q.have_r;
        s_d.have_r    = 1'b0;
        s_d.fr        = 1'b1;
        s_d.ft        = t;
        s_d.fa        = bus.dw_addr;
        s_d.pend_rd   = 1'b1;
        s_d.pend_half = bus.halfword_address_bit;
        s_d.pend_big  = big;
      end
    end
    // fetch_data must be valid in the same cycle as fetch_req
    // a landing fetch wins over a strobe in the same cycle
    if (s_q.pend_rd) begin
      // R12 endian then swap on reads
      raw = hswap(endian(fetch_data, s_q.pend_big), swap_on);
      s_d.have_r  = 1'b1;
      s_d.r_half  = s_q.pend_half;
      s_d.r_stage = raw;
      s_d.rv      = 1'b1;
      s_d.rd      = s_q.pend_half ? raw[31:16] : raw[15:0];
    end
  end

  // =========================================================
  // state register
  // clearing the whole struct also empties both staging slots
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // =========================================================
  // outputs, each straight from the state register
  assign commit_valid  = s_q.cv;
  assign commit_data   = s_q.cd;
  assign commit_target = s_q.ct;
  assign commit_addr   = s_q.ca;
  assign write_dropped = s_q.wd;
  assign fetch_req     = s_q.fr;
  assign fetch_target  = s_q.ft;
  assign fetch_addr    = s_q.fa;
  assign read_restart  = s_q.rr;
  assign bus.rdata     = s_q.rd;
  assign bus.rvalid    = s_q.rv;
endmodule : hdp_device
`default_nettype wire

//--- logic/hdp_host.sv
// processor end: issues each dword as a pair of halfword accesses
`timescale 1ns/1ps
`default_nettype none
`include "hdp_cfg.svh"
module hdp_host (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // host bus
  hdp_if.host                   bus,
  // user request
  input  wire logic             req_valid,
  input  wire logic             req_write,
  input  wire logic             req_high_first,
  input  wire logic             req_fifo_sel,
  input  wire hdp_pkg::dw_addr_t req_addr,
  input  wire hdp_pkg::dword_t  req_wdata,
  output logic                  req_ready,
  // user answer
  output logic                  resp_valid,
  output hdp_pkg::dword_t       resp_data
);
  import hdp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FIRST, ST_WAIT1, ST_SECOND, ST_WAIT2
  } phase_e;

  typedef struct packed {
    phase_e   ph;
    logic     wr;
    logic     hf;
    logic     fs;
    dw_addr_t a;
    dword_t   d;
    logic     ws;
    logic     rs;
    logic     hb;
    half_t    wdat;
    logic     rdy;
    logic     rv;
    dword_t   rdat;
  } state_s;

  state_s s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.ws = 1'b0;
    s_d.rs = 1'b0;
    s_d.rv = 1'b0;
    unique case (s_q.ph)
      ST_IDLE: begin
        s_d.rdy = 1'b1;
        if (req_valid && s_q.rdy) begin
          s_d.rdy = 1'b0;
          s_d.wr  = req_write;
          s_d.hf  = req_high_first;
          s_d.fs  = req_fifo_sel;
          s_d.a   = req_addr;
          s_d.d   = req_wdata;
          s_d.ph  = ST_FIRST;
        end
      end
      // R1 R5 first half, R2 address held
      ST_FIRST: begin
        s_d.hb   = s_q.hf;
        s_d.wdat = s_q.hf ? s_q.d[31:16] : s_q.d[15:0];
        s_d.ws   = s_q.wr;
        s_d.rs   = !s_q.wr;
        s_d.ph   = ST_WAIT1;
      end
      ST_WAIT1: begin
        if (s_q.wr) begin
          s_d.ph = ST_SECOND;
        end else if (bus.rvalid) begin
          if (s_q.hf) s_d.rdat[31:16] = bus.rdata;
          else        s_d.rdat[15:0]  = bus.rdata;
          s_d.ph = ST_SECOND;
        end
      end
      // R3 other half second
      ST_SECOND: begin
        s_d.hb   = !s_q.hf;
        s_d.wdat = s_q.hf ? s_q.d[15:0] : s_q.d[31:16];
        s_d.ws   = s_q.wr;
        s_d.rs   = !s_q.wr;
        s_d.ph   = ST_WAIT2;
      end
      ST_WAIT2: begin
        if (s_q.wr) begin
          s_d.ph  = ST_IDLE;
          s_d.rdy = 1'b1;
        end else if (bus.rvalid) begin
          if (s_q.hf) s_d.rdat[15:0]  = bus.rdata;
          else        s_d.rdat[31:16] = bus.rdata;
          s_d.rv  = 1'b1;
          s_d.ph  = ST_IDLE;
          s_d.rdy = 1'b1;
        end
      end
      default: s_d.ph = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.wr_stb               = s_q.ws;
  assign bus.rd_stb               = s_q.rs;
  assign bus.dw_addr              = s_q.a;
  assign bus.halfword_address_bit = s_q.hb;
  assign bus.fifo_sel             = s_q.fs;
  assign bus.wdata                = s_q.wdat;
  assign req_ready                = s_q.rdy;
  assign resp_valid               = s_q.rv;
  assign resp_data                = s_q.rdat;
endmodule : hdp_host
`default_nettype wire

//--- shared/hdp_cfg.svh
// constants for the host halfword/dword data path
// Notes on behaviour
// R1: host writes dword as two halfword writes
// R2: upper address bits fixed within one pair
// R3: accept halves in either order
// R4: repeated same-half write drops the dword
// R5: host reads dword as two halfword reads
// R6: repeated same-half read restarts pairing, retry
// R7: separate endian select for port and direct
// R8: port path big endian when port bit set
// R9: direct path big endian when direct bit set
// R10: csr and status fifo ignore endian bits
// R11: halfword swap covers every host access
// R12: writes swap then endian; reads reverse order
// R13: little endian: bit1 high gives bytes 3,2
// R14: big endian: bit1 high gives bytes 0,1
// R15: swap only when control is all ones
// R16: stage first half, commit on second
`ifndef HDP_CFG_SVH
`define HDP_CFG_SVH
`define HDP_SWAP_ALL_ONES 32'hffff_ffff
`define HDP_RST_WORD      32'h0000_0000
`define HDP_RST_ADDR      5'h00
`endif

//--- shared/hdp_if.sv
// parallel host bus between the processor end and the device end
`timescale 1ns/1ps
`default_nettype none
interface hdp_if;
  import hdp_pkg::*;
  logic     wr_stb;
  logic     rd_stb;
  dw_addr_t dw_addr;
  logic     halfword_address_bit;
  logic     fifo_sel;
  half_t    wdata;
  half_t    rdata;
  logic     rvalid;
  modport device (
    input  wr_stb, rd_stb, dw_addr, halfword_address_bit, fifo_sel, wdata,
    output rdata, rvalid
  );
  modport host (
    output wr_stb, rd_stb, dw_addr, halfword_address_bit, fifo_sel, wdata,
    input  rdata, rvalid
  );
endinterface : hdp_if
`default_nettype wire

//--- shared/hdp_pkg.sv
// types shared by both ends of the host data path
package hdp_pkg;
  // which internal target an access reaches
  typedef enum logic [1:0] {
    TGT_CSR,
    TGT_STATUS_FIFO,
    TGT_DATA_PORT,
    TGT_DATA_DIRECT
  } target_e;
  typedef logic [31:0] dword_t;
  typedef logic [15:0] half_t;
  typedef logic [4:0]  dw_addr_t;
endpackage : hdp_pkg
